// ---- lbp_consts.vh ----
// Register offsets, field positions, reset values and timing constants of the LED PWM block
`ifndef LBP_CONSTS_VH
`define LBP_CONSTS_VH
`define LBP_ADDR_IDLE 8'ha0
`define LBP_ADDR_MASTER 8'ha1
`define LBP_ADDR_SETUP0 8'hb0
`define LBP_ADDR_CTRL0 8'hb1
`define LBP_ADDR_RAMP0 8'hb2
`define LBP_ADDR_INT_EN 8'hb3
`define LBP_ADDR_INT_STA 8'hb7
`define LBP_CH_STRIDE 8'h04
`define LBP_RESET_VAL 8'h00
`define LBP_BRIGHT_HI 7
`define LBP_BRIGHT_LO 4
`define LBP_TIMING_HI 3
`define LBP_TIMING_LO 1
`define LBP_RAMP_BIT 0
`define LBP_PER0_HI 7
`define LBP_PER0_LO 6
`define LBP_PER1_HI 5
`define LBP_PER1_LO 4
`define LBP_REP_HI 3
`define LBP_REP_LO 1
`define LBP_ORDER_BIT 0
`define LBP_RDOWN_HI 5
`define LBP_RDOWN_LO 3
`define LBP_RUP_HI 2
`define LBP_RUP_LO 0
`define LBP_UNIT_MS 20
`define LBP_CLK_HZ 10000000
`define LBP_UNIT_CYCLES (`LBP_UNIT_MS * (`LBP_CLK_HZ / 1000))
`endif

// ---- lbp_slot_timer.v ----
// Per-channel slot timer producing 1/128 time-unit ticks
`timescale 1ns/1ps
module lbp_slot_timer #(
  parameter SLOT_CYCLES = 1562
) (
  input wire clock,
  input wire rst_n,
  input wire run,
  output reg tick
);
  reg [31:0] count;
  always @(posedge clock) begin
    if (!rst_n || !run) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (count >= SLOT_CYCLES - 1) begin
      count <= 32'h0;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // lbp_slot_timer

// ---- lbp_controller.v ----
// Four-channel LED blink and brightness PWM controller with byte register port
`timescale 1ns/1ps
`include "lbp_consts.vh"
module lbp_controller #(
  parameter UNIT_CYCLES = `LBP_UNIT_CYCLES
) (
  input wire clock,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire [3:0] gpio_out,
  output wire [3:0] pin_out,
  output wire irq
);
  localparam SLOT_CYCLES = UNIT_CYCLES / 128;
  localparam ST_IDLE = 2'd0;
  localparam ST_ON = 2'd1;
  localparam ST_OFF = 2'd2;
  localparam ST_DONE = 2'd3;

  reg [7:0] idle_level;
  reg [7:0] master;
  reg [7:0] int_en;
  reg [3:0] int_sta;
  reg [7:0] setup [0:3];
  reg [7:0] ctrl [0:3];
  reg [7:0] ramp [0:3];
  wire [3:0] pwm_line;
  wire [3:0] done_evt;
  wire [3:0] run;

  // Register write port
  integer i;
  always @(posedge clock) begin
    if (!rst_n) begin
      idle_level <= `LBP_RESET_VAL;
      master <= `LBP_RESET_VAL;
      int_en <= `LBP_RESET_VAL;
      for (i = 0; i < 4; i = i + 1) begin
        setup[i] <= `LBP_RESET_VAL;
        ctrl[i] <= `LBP_RESET_VAL;
        ramp[i] <= `LBP_RESET_VAL;
      end
    end else if (reg_write) begin
      if (reg_addr == `LBP_ADDR_IDLE)
        idle_level <= {4'h0, reg_wdata[3:0]};
      if (reg_addr == `LBP_ADDR_MASTER)
        master <= reg_wdata;
      if (reg_addr == `LBP_ADDR_INT_EN)
        int_en <= {4'h0, reg_wdata[3:0]};
      for (i = 0; i < 4; i = i + 1) begin
        if (reg_addr == `LBP_ADDR_SETUP0 + `LBP_CH_STRIDE * i[7:0])
          setup[i] <= reg_wdata;
        if (reg_addr == `LBP_ADDR_CTRL0 + `LBP_CH_STRIDE * i[7:0])
          ctrl[i] <= reg_wdata;
        if (reg_addr == `LBP_ADDR_RAMP0 + `LBP_CH_STRIDE * i[7:0])
          ramp[i] <= {2'b00, reg_wdata[5:0]};
      end
    end
  end

  // Completion status, write one to clear, set wins
  integer k;
  always @(posedge clock) begin
    if (!rst_n) begin
      int_sta <= 4'h0;
    end else begin
      for (k = 0; k < 4; k = k + 1) begin
        if (done_evt[k])
          int_sta[k] <= 1'b1;
        else if (reg_write && reg_addr == `LBP_ADDR_INT_STA && reg_wdata[k])
          int_sta[k] <= 1'b0;
      end
    end
  end

  assign irq = |(int_sta & int_en[3:0]);

  // Read port
  integer j;
  always @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= 8'h00;
      if (reg_addr == `LBP_ADDR_IDLE)
        reg_rdata <= idle_level;
      if (reg_addr == `LBP_ADDR_MASTER)
        reg_rdata <= master;
      if (reg_addr == `LBP_ADDR_INT_EN)
        reg_rdata <= int_en;
      if (reg_addr == `LBP_ADDR_INT_STA)
        reg_rdata <= {4'h0, int_sta};
      for (j = 0; j < 4; j = j + 1) begin
        if (reg_addr == `LBP_ADDR_SETUP0 + `LBP_CH_STRIDE * j[7:0])
          reg_rdata <= setup[j];
        if (reg_addr == `LBP_ADDR_CTRL0 + `LBP_CH_STRIDE * j[7:0])
          reg_rdata <= ctrl[j];
        if (reg_addr == `LBP_ADDR_RAMP0 + `LBP_CH_STRIDE * j[7:0])
          reg_rdata <= ramp[j];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      reg [1:0] state;
      reg [1:0] next_state;
      reg [3:0] slot;
      reg [6:0] sub;
      reg [7:0] unit_div;
      reg [2:0] units;
      reg [2:0] pairs;
      reg half;
      reg [3:0] level;
      reg ramping_down;
      reg [12:0] step_cnt;
      reg line;
      wire tick;
      wire [2:0] timing = setup[g][`LBP_TIMING_HI:`LBP_TIMING_LO];
      wire [3:0] bright = setup[g][`LBP_BRIGHT_HI:`LBP_BRIGHT_LO];
      wire ramp_mode = setup[g][`LBP_RAMP_BIT];
      wire [1:0] per0 = ctrl[g][`LBP_PER0_HI:`LBP_PER0_LO];
      wire [1:0] per1 = ctrl[g][`LBP_PER1_HI:`LBP_PER1_LO];
      wire [2:0] rep = ctrl[g][`LBP_REP_HI:`LBP_REP_LO];
      wire order = ctrl[g][`LBP_ORDER_BIT];
      wire [2:0] rup = ramp[g][`LBP_RUP_HI:`LBP_RUP_LO];
      wire [2:0] rdn = ramp[g][`LBP_RDOWN_HI:`LBP_RDOWN_LO];
      reg [7:0] unit_len;
      reg [7:0] step_len;
      reg [2:0] cur_len;
      reg pin_level;
      wire [2:0] on_len = {1'b0, per0} + 3'd1;
      wire [2:0] off_len = {1'b0, per1};
      wire [2:0] rcode = ramping_down ? rdn : rup;
      wire unit_end = tick && sub == 7'h7f && unit_div == unit_len - 8'h01;

      // Ramp step and lead-in of the descent, in slots
      wire [12:0] step_total = {5'h00, step_len} * {5'h00, unit_len};
      wire [19:0] down_lead = {7'h00, step_total} * {16'h0000, bright};
      wire [19:0] unit_pos = {5'h00, unit_div, sub};
      wire [19:0] unit_ticks = {5'h00, unit_len, 7'h00};
      wire down_due = units == cur_len - 3'd1 && unit_pos + down_lead >= unit_ticks;

      // With no OFF interval every ON interval closes a pair
      wire last_half = half || off_len == 3'd0;
      wire interval_end = unit_end && units == cur_len - 3'd1;
      wire pair_end = interval_end && last_half;

      // Time unit doubles with each timing code
      always @* begin
        case (timing)
          3'd0: unit_len = 8'h01;
          3'd1: unit_len = 8'h02;
          3'd2: unit_len = 8'h04;
          3'd3: unit_len = 8'h08;
          3'd4: unit_len = 8'h10;
          3'd5: unit_len = 8'h20;
          3'd6: unit_len = 8'h40;
          3'd7: unit_len = 8'h80;
          default: unit_len = 8'h01;
        endcase
      end

      // Slots per level step at timing code 0, scaled by unit_len; reserved codes act as the slowest code
      always @* begin
        case (rcode)
          3'd0: step_len = 8'h20;
          3'd1: step_len = 8'h10;
          3'd2: step_len = 8'h08;
          3'd3: step_len = 8'h04;
          3'd4: step_len = 8'h02;
          3'd5: step_len = 8'h01;
          default: step_len = 8'h20;
        endcase
      end

      // Length of the running interval in time units
      always @* begin
        case (state)
          ST_ON: cur_len = on_len;
          ST_OFF: cur_len = off_len;
          default: cur_len = 3'd0;
        endcase
      end

      assign run[g] = master[g] && state != ST_DONE;

      lbp_slot_timer #(.SLOT_CYCLES(SLOT_CYCLES)) u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .run(run[g]),
        .tick(tick)
      );

      always @* begin
        next_state = state;
        case (state)
          ST_IDLE: begin
            if (master[g] && order)
              next_state = ST_OFF;
            else if (master[g])
              next_state = ST_ON;
          end
          ST_ON: begin
            if (!master[g])
              next_state = ST_IDLE;
            else if (pair_end && rep != 3'd0 && pairs == rep - 3'd1)
              next_state = ST_DONE;
            else if (interval_end)
              next_state = (off_len == 3'd0) ? ST_ON : ST_OFF;
          end
          ST_OFF: begin
            if (!master[g])
              next_state = ST_IDLE;
            else if (pair_end && rep != 3'd0 && pairs == rep - 3'd1)
              next_state = ST_DONE;
            else if (interval_end || off_len == 3'd0)
              next_state = ST_ON;
          end
          ST_DONE: begin
            if (!master[g])
              next_state = ST_IDLE;
          end
          default: next_state = ST_IDLE;
        endcase
      end

      // Sequencer, duty slot counter and ramp level
      always @(posedge clock) begin
        if (!rst_n) begin
          state <= ST_IDLE;
          slot <= 4'h0;
          sub <= 7'h00;
          unit_div <= 8'h00;
          units <= 3'd0;
          pairs <= 3'd0;
          half <= 1'b0;
          level <= 4'h0;
          ramping_down <= 1'b0;
          step_cnt <= 13'h0000;
          line <= 1'b0;
        end else begin
          state <= next_state;
          if (state != next_state || next_state == ST_IDLE) begin
            units <= 3'd0;
            unit_div <= 8'h00;
            sub <= 7'h00;
            step_cnt <= 13'h0000;
            ramping_down <= 1'b0;
            level <= ramp_mode ? 4'h0 : bright;
            if (next_state == ST_IDLE) begin
              pairs <= 3'd0;
              half <= 1'b0;
            end else if (state != ST_IDLE) begin
              half <= ~half;
              if (half)
                pairs <= pairs + 3'd1;
            end
          end else if (tick) begin
            slot <= slot + 4'h1;
            sub <= sub + 7'h01;
            if (sub == 7'h7f) begin
              if (unit_div == unit_len - 8'h01) begin
                unit_div <= 8'h00;
                units <= (units == cur_len - 3'd1) ? 3'd0 : units + 3'd1;
                if (units == cur_len - 3'd1 && state == ST_ON && off_len == 3'd0) begin
                  pairs <= pairs + 3'd1;
                  level <= ramp_mode ? 4'h0 : bright;
                  ramping_down <= 1'b0;
                end
              end else begin
                unit_div <= unit_div + 8'h01;
              end
            end
            // Ramp steps one level per step_total slots
            if (ramp_mode && state == ST_ON) begin
              if (step_cnt >= step_total - 13'h0001) begin
                step_cnt <= 13'h0000;
                if (!ramping_down && level < bright)
                  level <= level + 4'h1;
                else if (ramping_down && level != 4'h0)
                  level <= level - 4'h1;
              end else begin
                step_cnt <= step_cnt + 13'h0001;
              end
              // Start descending so the ramp ends with the interval
              if (!ramping_down && bright != 4'h0 && down_due) begin
                ramping_down <= 1'b1;
              end
            end
          end
          // Duty: high for (level+1) of 16 slots
          line <= (state == ST_ON) && (slot <= level);
        end
      end

      assign done_evt[g] = state != ST_DONE && next_state == ST_DONE && rep != 3'd0;
      assign pwm_line[g] = run[g] ? line : idle_level[g];

      // Pin routing between the PWM line and plain GPIO
      always @* begin
        case (master[4 + g])
          1'b1: pin_level = pwm_line[g];
          default: pin_level = gpio_out[g];
        endcase
      end
      assign pin_out[g] = pin_level;
    end
  endgenerate
endmodule // lbp_controller

// ---- lbp_props.sv ----
// Port checker of the LED PWM controller
`timescale 1ns/1ps
module lbp_props (
  input wire clock,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  input wire [3:0] gpio_out,
  input wire [3:0] pin_out,
  input wire irq
);
  reg [7:0] idl, mst, ien, rmp, ctl;
  // Shadow copies of the written idle, master, interrupt enable and channel 0 ramp and ctrl registers
  always @(posedge clock) begin
    if (!rst_n) begin
      {idl, mst, ien, rmp, ctl} <= 40'h0;
    end else if (reg_write) begin
      if (reg_addr == 8'ha0) idl <= reg_wdata & 8'h0f;
      if (reg_addr == 8'ha1) mst <= reg_wdata;
      if (reg_addr == 8'hb3) ien <= reg_wdata & 8'h0f;
      if (reg_addr == 8'hb2) rmp <= reg_wdata & 8'h3f;
      if (reg_addr == 8'hb1) ctl <= reg_wdata;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_rd(a);
    reg_read && reg_addr == a;
  endsequence
  a_unmapped_read: assert property (s_rd(8'hff) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved");
  a_idle_level: assert property (((mst[7:4] & ~mst[3:0]) & (pin_out ^ idl[3:0])) == 4'h0)
    else $error("idle level wrong");
  a_gpio_pass: assert property ((~mst[7:4] & (pin_out ^ gpio_out)) == 4'h0)
    else $error("gpio not passed");
  a_irq_masked: assert property (ien[3:0] == 4'h0 |-> !irq)
    else $error("masked irq");
  a_idle_readback: assert property (s_rd(8'ha0) |=> reg_rdata == idl)
    else $error("idle readback");
  a_ramp_readback: assert property (s_rd(8'hb2) |=> reg_rdata == rmp)
    else $error("ramp readback");
  a_ctrl_readback: assert property (s_rd(8'hb1) |=> reg_rdata == ctl)
    else $error("ctrl readback");
endmodule // lbp_props
bind lbp_controller lbp_props u_props (.clock(clock), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .gpio_out(gpio_out),
  .pin_out(pin_out), .irq(irq));

// ---- lbp_led_model.sv ----
// LED model that counts lit clock cycles
`timescale 1ns/1ps
module lbp_led_model (
  input wire clock,
  input wire clear,
  input wire pin,
  output reg [15:0] lit
);
  always @(posedge clock) begin
    if (clear) lit <= 16'h0000;
    else if (pin) lit <= lit + 16'h0001;
  end
endmodule // lbp_led_model

// ---- tb_lbp_controller.sv ----
// Self-checking bench of the LED PWM controller
`timescale 1ns/1ps
module tb_lbp_controller;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg [3:0] gpio_out = 4'h9;
  reg clr = 1'b1;
  reg [15:0] k;
  wire [7:0] reg_rdata;
  wire [3:0] pin_out;
  wire irq;
  wire [15:0] lit;
  integer bad_count = 0;
  integer n_tests = 0;
  integer i;
  always #50 clock = ~clock;
  lbp_controller #(.UNIT_CYCLES(1280)) u_dut (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .gpio_out(gpio_out),
    .pin_out(pin_out), .irq(irq));
  lbp_led_model u_led (.clock(clock), .clear(clr), .pin(pin_out[0]), .lit(lit));
  task conclude; begin
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  end endtask
  task check(input [15:0] got, input [15:0] exp); begin
    n_tests = n_tests + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  end endtask
  task tick(input integer n); begin
    repeat (n) @(posedge clock);
    #1;
  end endtask
  task wr(input [7:0] a, input [7:0] d); begin
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    tick(1);
    reg_write = 1'b0;
  end endtask
  task rd(input [7:0] a, input [7:0] e); begin
    reg_addr = a;
    reg_read = 1'b1;
    tick(1);
    reg_read = 1'b0;
    tick(1);
    check({8'h00, reg_rdata}, {8'h00, e});
  end endtask
  initial begin
    tick(4);
    rst_n = 1'b1;
    check(pin_out, gpio_out);
    for (i = 0; i < 4; i = i + 1) rd(8'hb0 + i[7:0], 8'h00);
    rd(8'ha1, 8'h00);
    rd(8'hff, 8'h00);
    wr(8'ha0, 8'hff);
    rd(8'ha0, 8'h0f);
    wr(8'hb2, 8'hff);
    rd(8'hb2, 8'h3f);
    wr(8'hbd, 8'ha5);
    rd(8'hbd, 8'ha5);
    wr(8'ha0, 8'h05);
    wr(8'ha1, 8'hf0);
    check(pin_out, 4'h5);
    wr(8'ha1, 8'h00);
    gpio_out = 4'h6;
    tick(1);
    check(pin_out, 4'h6);
    wr(8'hb3, 8'h03);
    // Duty per brightness code, endless run on channel 0
    for (k = 0; k < 16; k = k + 5) begin
      wr(8'ha1, 8'hf0);
      wr(8'hb0, {k[3:0], 4'h0});
      wr(8'hb1, 8'h00);
      wr(8'ha1, 8'hf1);
      tick(3);
      clr = 1'b0;
      tick(1280);
      clr = 1'b1;
      check(lit, (k + 16'd1) * 16'd80);
    end
    // Ramp mode starts from minimum level, so the LED is far from full on
    wr(8'ha1, 8'hf0);
    wr(8'hb0, 8'hf1);
    wr(8'ha1, 8'hf1);
    tick(3);
    clr = 1'b0;
    tick(300);
    clr = 1'b1;
    check(lit <= 16'd20, 1'b1);
    rd(8'hb1, 8'h00);
    rd(8'hb7, 8'h00);
    // Channel 1: one pair, OFF first, then completion
    wr(8'hb4, 8'hf0);
    wr(8'hb5, 8'h13);
    wr(8'hb3, 8'h02);
    wr(8'ha1, 8'hf3);
    tick(600);
    check(pin_out[1], 1'b0);
    tick(1280);
    check(pin_out[1], 1'b1);
    i = 0;
    while (irq !== 1'b1 && i < 2000) begin
      tick(1);
      i = i + 1;
    end
    if (i >= 2000) begin
      bad_count = bad_count + 1;
      conclude;
    end
    rd(8'hb7, 8'h02);
    tick(200);
    check(pin_out[1], 1'b0);
    wr(8'hb3, 8'h00);
    check(irq, 1'b0);
    wr(8'hb3, 8'h02);
    check(irq, 1'b1);
    wr(8'hb7, 8'h02);
    check(irq, 1'b0);
    conclude;
  end
endmodule // tb_lbp_controller
